// ### hdl/icc_chain.sv
// Analog and pulse input conditioning chain with motor routing
// How it works
// - Analog input disabled gives capture zero, sample ignored.
// - Absolute mode reports the pin voltage uncorrected.
// - Relative mode rescales against the 5V rail, rail reads 5.0V.
// - Capture above max or below min limit raises the set action.
// - Raw capture is scaled to -1000..+1000 from min, center, max.
// - Center equal to min gives 0..1000 only.
// - Deadband 0 to 50 percent around center gives zero.
// - Deadband shifts the start; full travel still gives full scale.
// - After deadband, linear or three exp or three log curves.
// - Exp softens the start of travel; log acts strongest there.
// - Result routed as command or feedback to chosen motors.
// - Pulse input disabled gives capture zero.
// - Pulse width mode measures high time of each pulse.
// - Duty mode measures high time over whole period.
// - Frequency mode measures pulse repetition rate.
// - Count mode counts pulses; count readable on query.
// - Count clears via disabled then count mode; host does this.
// - Pulse captures share limit, scale, deadband and curve stages.
// - Limit actions: none, stops, invert, limits, script, home load.
`timescale 1ns/1ps
`default_nettype none
module icc_chain
   import icc_pkg::*;
(
   input  wire logic                        SYS_CLK_IN,
   input  wire logic                        RST_B_IN,
   input  wire logic                        CE_IN,
   input  wire icc_pkg::icc_raw_t           ANA_MV_IN,
   input  wire logic                        ANA_VALID_IN,
   input  wire icc_pkg::icc_raw_t           RAIL_MV_IN,
   input  wire icc_pkg::icc_ana_mode_e      ANA_MODE_IN,
   input  wire logic                        PULSE_IN,
   input  wire icc_pkg::icc_pul_mode_e      PUL_MODE_IN,
   input  wire logic                        PULSE_COUNT_QUERY_IN,
   input  wire icc_pkg::icc_cfg_s [1:0]     CFG_IN,
   output icc_pkg::icc_raw_t [1:0]          CAPTURE_OUT,
   output icc_pkg::icc_val_t [1:0]          VALUE_OUT,
   output logic [1:0]                       VALUE_VALID_OUT,
   output icc_pkg::icc_action_e [1:0]       LIM_HI_ACT_OUT,
   output icc_pkg::icc_action_e [1:0]       LIM_LO_ACT_OUT,
   output logic [1:0]                       LIM_EVT_OUT,
   output icc_pkg::icc_val_t [1:0]          CMD_OUT,
   output logic [1:0]                       CMD_VALID_OUT,
   output icc_pkg::icc_val_t [1:0]          FB_OUT,
   output logic [1:0]                       FB_VALID_OUT,
   output logic [31:0]                      PULSE_COUNT_OUT
);
   logic                    rst_s1;
   logic                    rst_n;
   icc_raw_t                ana_cap;
   logic                    ana_vld;
   logic [15:0]             pul_cap;
   logic                    pul_vld;
   logic [31:0]             pul_count;
   icc_raw_t [NUM_IN-1:0]   raw;
   logic [NUM_IN-1:0]       raw_vld;
   icc_val_t [NUM_IN-1:0]   scaled;
   logic [NUM_IN-1:0]       scaled_vld;
   icc_val_t [NUM_IN-1:0]   banded;
   logic [NUM_IN-1:0]       banded_vld;
   icc_val_t [NUM_IN-1:0]   curved;
   logic [NUM_IN-1:0]       curved_vld;
   logic [NUM_IN-1:0]       hi_hit;
   logic [NUM_IN-1:0]       lo_hit;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   // Rail correction; a dead rail reads as zero rather than dividing by it
   function automatic icc_raw_t rel_mv(input icc_raw_t mv, input icc_raw_t rail);
      logic [31:0] r;
      r = 32'h00000000;
      if (rail != 16'h0000) r = (32'(mv) * RAIL_MV) / 32'(rail);
      return (r > 32'(RAW_MAX)) ? 16'hFFFF : r[15:0];
   endfunction : rel_mv

   // Used once per input in the generate loop
   function automatic icc_val_t scale_f(input icc_raw_t r, input icc_cfg_s c);
      int v;
      v = 0;
      if (r >= c.cal_max) begin
         v = FULL_SCALE;
      end else if (r <= c.cal_min) begin
         v = (c.cal_ctr == c.cal_min) ? 0 : -FULL_SCALE;
      end else if (r < c.cal_ctr) begin
         v = -(FULL_SCALE * (int'(c.cal_ctr) - int'(r))
               / (int'(c.cal_ctr) - int'(c.cal_min)));
      end else begin
         v = FULL_SCALE * (int'(r) - int'(c.cal_ctr))
             / (int'(c.cal_max) - int'(c.cal_ctr));
      end
      return icc_val_t'(v);
   endfunction : scale_f

   // Deadband removes the band then stretches the rest back to full scale
   function automatic icc_val_t band_f(input icc_val_t v, input logic [5:0] pct);
      int a;
      int b;
      int r;
      a = (v < 0) ? -int'(v) : int'(v);
      b = ((pct > 6'(DB_MAX_PCT)) ? DB_MAX_PCT : int'(pct)) * PCT_TO_SCALE;
      r = 0;
      if (a > b) r = (a - b) * FULL_SCALE / (FULL_SCALE - b);
      return (v < 0) ? icc_val_t'(-r) : icc_val_t'(r);
   endfunction : band_f

   // Analog capture stage
   always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         ana_cap <= RAW_RESET;
         ana_vld <= 1'b0;
      end else if (CE_IN) begin
         ana_vld <= ANA_VALID_IN || ANA_MODE_IN == AM_OFF;
         case (ANA_MODE_IN)
            AM_OFF:  ana_cap <= RAW_RESET;
            AM_ABS:  if (ANA_VALID_IN) ana_cap <= ANA_MV_IN;
            AM_REL:  if (ANA_VALID_IN) ana_cap <= rel_mv(ANA_MV_IN, RAIL_MV_IN);
            default: ana_cap <= RAW_RESET;
         endcase
      end
   end

   icc_pulse_cap u_pulse (
      .clk      (SYS_CLK_IN),
      .rst_n    (rst_n),
      .ce       (CE_IN),
      .pulse_in (PULSE_IN),
      .mode     (PUL_MODE_IN),
      .cap      (pul_cap),
      .cap_vld  (pul_vld),
      .count    (pul_count)
   );

   // Count is sampled on the query so the host reads a stable value
   always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         PULSE_COUNT_OUT <= 32'h00000000;
      end else if (CE_IN && PULSE_COUNT_QUERY_IN) begin
         PULSE_COUNT_OUT <= pul_count;
      end
   end

   // Pulse capture joins the common chain at the raw stage
   assign raw[ANA_CH]     = ana_cap;
   assign raw_vld[ANA_CH] = ana_vld;
   assign raw[PUL_CH]     = pul_cap;
   assign raw_vld[PUL_CH] = pul_vld;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_IN; gi++) begin : g_chain
         // Limit detection works on the raw capture, before scaling
         always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
            if (!rst_n) begin
               hi_hit[gi]         <= 1'b0;
               lo_hit[gi]         <= 1'b0;
               LIM_HI_ACT_OUT[gi] <= ACT_NONE;
               LIM_LO_ACT_OUT[gi] <= ACT_NONE;
               LIM_EVT_OUT[gi]    <= 1'b0;
            end else if (CE_IN) begin
               LIM_EVT_OUT[gi] <= 1'b0;
               if (raw_vld[gi]) begin
                  hi_hit[gi] <= raw[gi] > CFG_IN[gi].lim_max;
                  lo_hit[gi] <= raw[gi] < CFG_IN[gi].lim_min;
                  LIM_HI_ACT_OUT[gi] <= (raw[gi] > CFG_IN[gi].lim_max)
                                      ? CFG_IN[gi].max_action : ACT_NONE;
                  LIM_LO_ACT_OUT[gi] <= (raw[gi] < CFG_IN[gi].lim_min)
                                      ? CFG_IN[gi].min_action : ACT_NONE;
                  // Pulse only on entering a limit, not while held there
                  LIM_EVT_OUT[gi] <=
                     (raw[gi] > CFG_IN[gi].lim_max && !hi_hit[gi]) ||
                     (raw[gi] < CFG_IN[gi].lim_min && !lo_hit[gi]);
               end
            end
         end

         always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
            if (!rst_n) begin
               CAPTURE_OUT[gi] <= RAW_RESET;
               scaled[gi]      <= 12'sh000;
               scaled_vld[gi]  <= 1'b0;
            end else if (CE_IN) begin
               scaled_vld[gi] <= raw_vld[gi];
               if (raw_vld[gi]) begin
                  CAPTURE_OUT[gi] <= raw[gi];
                  scaled[gi]      <= scale_f(raw[gi], CFG_IN[gi]);
               end
            end
         end

         always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
            if (!rst_n) begin
               banded[gi]     <= 12'sh000;
               banded_vld[gi] <= 1'b0;
            end else if (CE_IN) begin
               banded_vld[gi] <= scaled_vld[gi];
               banded[gi] <= band_f(scaled[gi], CFG_IN[gi].deadband_pct);
            end
         end

         icc_curve u_curve (
            .clk     (SYS_CLK_IN),
            .rst_n   (rst_n),
            .ce      (CE_IN),
            .v_in    (banded[gi]),
            .vld_in  (banded_vld[gi]),
            .curve   (CFG_IN[gi].curve),
            .v_out   (curved[gi]),
            .vld_out (curved_vld[gi])
         );

         always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
            if (!rst_n) begin
               VALUE_OUT[gi]       <= 12'sh000;
               VALUE_VALID_OUT[gi] <= 1'b0;
            end else if (CE_IN) begin
               VALUE_VALID_OUT[gi] <= curved_vld[gi];
               if (curved_vld[gi]) VALUE_OUT[gi] <= curved[gi];
            end
         end
      end
   endgenerate

   // Routing: the highest-numbered input wins a motor claimed twice
   generate
      for (gi = 0; gi < NUM_MOT; gi++) begin : g_route
         always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
            if (!rst_n) begin
               CMD_OUT[gi]       <= 12'sh000;
               CMD_VALID_OUT[gi] <= 1'b0;
               FB_OUT[gi]        <= 12'sh000;
               FB_VALID_OUT[gi]  <= 1'b0;
            end else if (CE_IN) begin
               CMD_VALID_OUT[gi] <= 1'b0;
               FB_VALID_OUT[gi]  <= 1'b0;
               for (int k = 0; k < NUM_IN; k++) begin
                  if (curved_vld[k] && CFG_IN[k].motor_mask[gi]) begin
                     if (CFG_IN[k].use_as == USE_CMD) begin
                        CMD_OUT[gi]       <= curved[k];
                        CMD_VALID_OUT[gi] <= 1'b1;
                     end else if (CFG_IN[k].use_as == USE_FB) begin
                        FB_OUT[gi]       <= curved[k];
                        FB_VALID_OUT[gi] <= 1'b1;
                     end
                  end
               end
            end
         end
      end
   endgenerate
endmodule : icc_chain
`default_nettype wire

// ### hdl/icc_curve.sv
// Registered linear, exponential or logarithmic command correction
`timescale 1ns/1ps
`default_nettype none
module icc_curve
   import icc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   input  wire icc_val_t   v_in,
   input  wire logic       vld_in,
   input  wire icc_curve_e curve,
   output icc_val_t        v_out,
   output logic            vld_out
);
   int x;
   int q;
   int t;
   int y;

   // Quadratic shape; log is its mirror, so both meet ends at 0 and 1000
   always_comb begin
      x = (v_in < 0) ? -int'(v_in) : int'(v_in);
      q = x * x / FULL_SCALE;
      t = (curve >= CV_LOG_W) ? 2 * x - q : q;
      case (curve)
         CV_EXP_W, CV_LOG_W: y = (3 * x + t) / 4;
         CV_EXP_M, CV_LOG_M: y = (x + t) / 2;
         CV_EXP_S, CV_LOG_S: y = t;
         default:            y = x;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         v_out   <= 12'sh000;
         vld_out <= 1'b0;
      end else if (ce) begin
         vld_out <= vld_in;
         v_out   <= (v_in < 0) ? icc_val_t'(-y) : icc_val_t'(y);
      end
   end
endmodule : icc_curve
`default_nettype wire

// ### hdl/icc_pkg.sv
// Constants, types and configuration carrier for the input conditioning chain
package icc_pkg;
   localparam int NUM_IN        = 2;
   localparam int NUM_MOT       = 2;
   localparam int ANA_CH        = 0;
   localparam int PUL_CH        = 1;
   localparam int CLK_HZ        = 25_000_000;
   localparam int CLK_PERIOD_NS = 40;
   localparam int NS_PER_US     = 1000;
   localparam int CYC_PER_US    = NS_PER_US / CLK_PERIOD_NS;
   localparam int FULL_SCALE    = 1000;
   localparam int RAIL_MV       = 5000;
   localparam int DB_MAX_PCT    = 50;
   localparam int PCT_TO_SCALE  = FULL_SCALE / 100;
   localparam int RAW_MAX       = 16'hFFFF;
   localparam logic [23:0] CNT_SAT   = 24'hFFFFFF;
   localparam logic [15:0] RAW_RESET = 16'h0000;

   typedef logic signed [11:0] icc_val_t;
   typedef logic [15:0]        icc_raw_t;

   typedef enum logic [1:0] {AM_OFF, AM_ABS, AM_REL} icc_ana_mode_e;
   typedef enum logic [2:0] {
      PM_OFF, PM_WIDTH, PM_DUTY, PM_FREQ, PM_COUNT
   } icc_pul_mode_e;
   typedef enum logic [2:0] {
      CV_LIN, CV_EXP_W, CV_EXP_M, CV_EXP_S, CV_LOG_W, CV_LOG_M, CV_LOG_S
   } icc_curve_e;
   typedef enum logic [3:0] {
      ACT_NONE, ACT_SAFE_STOP, ACT_ESTOP, ACT_MOT_STOP, ACT_INVERT,
      ACT_FWD_LIM, ACT_REV_LIM, ACT_SCRIPT, ACT_LOAD_HOME
   } icc_action_e;
   typedef enum logic [1:0] {USE_NONE, USE_CMD, USE_FB} icc_use_e;

   typedef struct packed {
      icc_raw_t              lim_min;
      icc_raw_t              lim_max;
      icc_action_e           min_action;
      icc_action_e           max_action;
      icc_raw_t              cal_min;
      icc_raw_t              cal_ctr;
      icc_raw_t              cal_max;
      logic [5:0]            deadband_pct;
      icc_curve_e            curve;
      icc_use_e              use_as;
      logic [NUM_MOT-1:0]    motor_mask;
   } icc_cfg_s;
endpackage : icc_pkg

// ### hdl/icc_pulse_cap.sv
// Pulse input capture: width, duty, frequency and pulse count
`timescale 1ns/1ps
`default_nettype none
module icc_pulse_cap
   import icc_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          ce,
   input  wire logic          pulse_in,
   input  wire icc_pul_mode_e mode,
   output logic [15:0]        cap,
   output logic               cap_vld,
   output logic [31:0]        count
);
   logic        prev;
   logic        seen_rise;
   logic [23:0] hi_cyc;
   logic [23:0] per_cyc;
   logic [23:0] on_cyc;
   logic        rise;
   logic        fall;

   assign rise = pulse_in & ~prev;
   assign fall = ~pulse_in & prev;

   function automatic logic [15:0] sat16(input logic [31:0] v);
      return (v > 32'(RAW_MAX)) ? 16'hFFFF : v[15:0];
   endfunction : sat16

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev      <= 1'b0;
         seen_rise <= 1'b0;
         hi_cyc    <= 24'h000000;
         per_cyc   <= 24'h000000;
         on_cyc    <= 24'h000000;
      end else if (ce) begin
         prev <= pulse_in;
         if (pulse_in && hi_cyc != CNT_SAT) hi_cyc <= hi_cyc + 24'h000001;
         if (rise) hi_cyc <= 24'h000001;
         if (fall) on_cyc <= hi_cyc;
         per_cyc <= rise ? 24'h000001
                 : (per_cyc == CNT_SAT ? per_cyc : per_cyc + 24'h000001);
         if (rise) seen_rise <= 1'b1;
      end
   end

   // Disabling clears the count, so off then count restarts it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 32'h00000000;
      end else if (ce) begin
         if (mode == PM_OFF) count <= 32'h00000000;
         else if (mode == PM_COUNT && rise) count <= count + 32'h00000001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cap     <= RAW_RESET;
         cap_vld <= 1'b0;
      end else if (ce) begin
         cap_vld <= 1'b0;
         case (mode)
            PM_OFF: begin
               cap     <= RAW_RESET;
               cap_vld <= 1'b1;
            end
            PM_WIDTH: if (fall) begin
               cap     <= sat16(32'(hi_cyc) / CYC_PER_US);
               cap_vld <= 1'b1;
            end
            // First rise has no full period behind it
            PM_DUTY: if (rise && seen_rise) begin
               cap     <= sat16(32'(on_cyc) * FULL_SCALE / 32'(per_cyc));
               cap_vld <= 1'b1;
            end
            PM_FREQ: if (rise && seen_rise) begin
               cap     <= sat16(CLK_HZ / 32'(per_cyc));
               cap_vld <= 1'b1;
            end
            PM_COUNT: if (rise) begin
               cap     <= sat16(count + 32'h00000001);
               cap_vld <= 1'b1;
            end
            default: cap_vld <= 1'b0;
         endcase
      end
   end
endmodule : icc_pulse_cap
`default_nettype wire

// ### tb/icc_chain_monitor.sv
// Timing and relation checker bound to the conditioning chain top
`timescale 1ns/1ps
`default_nettype none
module icc_chain_monitor
   import icc_pkg::*;
(
   input wire logic                   SYS_CLK_IN,
   input wire logic                   RST_B_IN,
   input wire logic                   CE_IN,
   input wire logic                   ANA_VALID_IN,
   input wire icc_pkg::icc_ana_mode_e ANA_MODE_IN,
   input wire icc_pkg::icc_pul_mode_e PUL_MODE_IN,
   input wire logic                   PULSE_COUNT_QUERY_IN,
   input wire icc_pkg::icc_cfg_s [1:0]    CFG_IN,
   input wire icc_pkg::icc_raw_t [1:0]    CAPTURE_OUT,
   input wire icc_pkg::icc_val_t [1:0]    VALUE_OUT,
   input wire logic [1:0]                 VALUE_VALID_OUT,
   input wire icc_pkg::icc_action_e [1:0] LIM_HI_ACT_OUT,
   input wire icc_pkg::icc_action_e [1:0] LIM_LO_ACT_OUT,
   input wire logic [1:0]                 LIM_EVT_OUT,
   input wire icc_pkg::icc_val_t [1:0]    CMD_OUT,
   input wire logic [1:0]                 CMD_VALID_OUT,
   input wire logic [31:0]                PULSE_COUNT_OUT
);
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RST_B_IN);

   property p_lat;
      CE_IN && ANA_VALID_IN ##1 CE_IN[*4] |=> VALUE_VALID_OUT[0];
   endproperty
   a_lat: assert property (p_lat)
      else $error("processed value not valid five edges after sample");
   property p_aoff;
      (CE_IN && ANA_MODE_IN == AM_OFF)[*3] |=> CAPTURE_OUT[0] == '0;
   endproperty
   a_aoff: assert property (p_aoff)
      else $error("analog capture not zero while disabled");
   property p_poff;
      (CE_IN && PUL_MODE_IN == PM_OFF)[*8] |=> CAPTURE_OUT[1] == '0;
   endproperty
   a_poff: assert property (p_poff)
      else $error("pulse capture not zero while disabled");
   property p_hi;
      LIM_HI_ACT_OUT[0] != ACT_NONE |-> CAPTURE_OUT[0] > CFG_IN[0].lim_max;
   endproperty
   a_hi: assert property (p_hi)
      else $error("high limit action without capture above max");
   property p_lo;
      LIM_LO_ACT_OUT[0] != ACT_NONE |-> CAPTURE_OUT[0] < CFG_IN[0].lim_min;
   endproperty
   a_lo: assert property (p_lo)
      else $error("low limit action without capture below min");
   property p_evt;
      LIM_EVT_OUT[0] |-> CAPTURE_OUT[0] > CFG_IN[0].lim_max
         || CAPTURE_OUT[0] < CFG_IN[0].lim_min;
   endproperty
   a_evt: assert property (p_evt)
      else $error("limit event with capture inside limits");
   property p_rng;
      VALUE_VALID_OUT[0] |-> $signed(VALUE_OUT[0]) <= 1000
         && $signed(VALUE_OUT[0]) >= -1000;
   endproperty
   a_rng: assert property (p_rng)
      else $error("processed value outside signed full scale");
   property p_cmd;
      VALUE_VALID_OUT[0] && CFG_IN[0].use_as == USE_CMD
         && CFG_IN[0].motor_mask[0]
         && !(CFG_IN[1].use_as == USE_CMD && CFG_IN[1].motor_mask[0])
         |-> CMD_VALID_OUT[0] && CMD_OUT[0] == VALUE_OUT[0];
   endproperty
   a_cmd: assert property (p_cmd)
      else $error("analog value not routed to motor command");
   property p_qry;
      (!PULSE_COUNT_QUERY_IN)[*2] |=> $stable(PULSE_COUNT_OUT);
   endproperty
   a_qry: assert property (p_qry)
      else $error("pulse count output changed without query");
endmodule : icc_chain_monitor

bind icc_chain icc_chain_monitor mon_u (
   .SYS_CLK_IN, .RST_B_IN, .CE_IN, .ANA_VALID_IN, .ANA_MODE_IN,
   .PUL_MODE_IN, .PULSE_COUNT_QUERY_IN, .CFG_IN, .CAPTURE_OUT, .VALUE_OUT,
   .VALUE_VALID_OUT, .LIM_HI_ACT_OUT, .LIM_LO_ACT_OUT, .LIM_EVT_OUT,
   .CMD_OUT, .CMD_VALID_OUT, .PULSE_COUNT_OUT
);
`default_nettype wire

// ### tb/icc_chain_test.sv
// Directed testbench for the input conditioning chain
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin \
   check_count++; \
   if ((a) !== (e)) begin \
      mismatches++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); \
   end \
end
module icc_chain_test;
   import icc_pkg::*;
   logic             clk = 1'b0;
   logic             rst_n = 1'b0;
   icc_raw_t         ana_mv = '0;
   icc_raw_t         rail_mv = 16'h1388;
   logic             ana_vld = 1'b0;
   icc_ana_mode_e    ana_mode = AM_ABS;
   icc_pul_mode_e    pul_mode = PM_OFF;
   logic             query = 1'b0;
   logic             ce = 1'b1;
   logic             pulse;
   logic             src_en = 1'b0;
   logic [15:0]      hi_cyc = 16'h0001;
   logic [15:0]      lo_cyc = 16'h0001;
   icc_cfg_s [1:0]   cfg = '0;
   icc_raw_t [1:0]   cap;
   icc_val_t [1:0]   val, cmd, fb;
   logic [1:0]       val_vld, evt, cmd_vld, fb_vld;
   icc_action_e [1:0] hi_act, lo_act;
   logic [31:0]      cnt;
   icc_raw_t         c;
   logic             e;
   int               mismatches = 0;
   int               check_count = 0;
   icc_raw_t mvs[6] = '{16'h0FA0, 16'h03E8, 16'h09C4, 16'h1130,
                        16'h0258, 16'h0CB2};
   icc_val_t exps[6] = '{12'h3E8, 12'hC18, 12'h000, 12'h3E8,
                         12'hC18, 12'h1F4};
   icc_val_t crv[7] = '{12'h190, 12'h154, 12'h118, 12'h0A0,
                        12'h1CC, 12'h208, 12'h280};

   always #20 clk = ~clk;

   icc_chain dut_u (
      .SYS_CLK_IN(clk), .RST_B_IN(rst_n), .CE_IN(ce),
      .ANA_MV_IN(ana_mv), .ANA_VALID_IN(ana_vld), .RAIL_MV_IN(rail_mv),
      .ANA_MODE_IN(ana_mode), .PULSE_IN(pulse), .PUL_MODE_IN(pul_mode),
      .PULSE_COUNT_QUERY_IN(query), .CFG_IN(cfg), .CAPTURE_OUT(cap),
      .VALUE_OUT(val), .VALUE_VALID_OUT(val_vld), .LIM_HI_ACT_OUT(hi_act),
      .LIM_LO_ACT_OUT(lo_act), .LIM_EVT_OUT(evt), .CMD_OUT(cmd),
      .CMD_VALID_OUT(cmd_vld), .FB_OUT(fb), .FB_VALID_OUT(fb_vld),
      .PULSE_COUNT_OUT(cnt)
   );
   icc_pulse_src src_u (
      .clk_in(clk), .en_in(src_en), .hi_in(hi_cyc), .lo_in(lo_cyc),
      .pulse_out(pulse)
   );

   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   // One sample; capture and event kept, value checked five edges on
   task ana(input icc_raw_t mv);
      cyc(1);
      ana_mv = mv;
      ana_vld = 1'b1;
      cyc(1);
      ana_vld = 1'b0;
      // Event stands one cycle only, so it is caught at the capture edge
      cyc(1);
      c = cap[0];
      e = evt[0];
      cyc(3);
      `CHK(val_vld[0], 1'b1)
   endtask : ana

   task ana_val(input icc_raw_t mv, input icc_val_t ev);
      ana(mv);
      `CHK(val[0], ev)
      `CHK(cmd[0], ev)
      `CHK(cmd_vld[0], 1'b1)
   endtask : ana_val

   task pul(input icc_pul_mode_e m, input logic [15:0] h, l,
            input int n, input icc_raw_t ex);
      pul_mode = m;
      hi_cyc = h;
      lo_cyc = l;
      src_en = 1'b1;
      cyc(n);
      `CHK(cap[1], ex)
   endtask : pul

   task qry;
      query = 1'b1;
      cyc(1);
      query = 1'b0;
      cyc(2);
   endtask : qry

   task test_done;
      $display("TB: checks=%0d mismatches=%0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : test_done

   initial begin
      #800000;
      mismatches++;
      test_done();
   end

   initial begin
      cfg[0].lim_min = 16'h01F4;
      cfg[0].lim_max = 16'h1194;
      cfg[0].cal_min = 16'h03E8;
      cfg[0].cal_ctr = 16'h09C4;
      cfg[0].cal_max = 16'h0FA0;
      cfg[0].use_as = USE_CMD;
      cfg[0].motor_mask = 2'b01;
      cfg[1].lim_max = 16'hFFFF;
      cfg[1].cal_ctr = 16'h01F4;
      cfg[1].cal_max = 16'h03E8;
      cfg[1].use_as = USE_FB;
      cfg[1].motor_mask = 2'b10;
      cyc(5);
      rst_n = 1'b1;
      cyc(3);
      for (int i = 0; i < 6; i++) begin
         ana_val(mvs[i], exps[i]);
         `CHK(c, mvs[i])
      end
      ana_mode = AM_REL;
      rail_mv = 16'h12C0;
      ana(16'h12C0);
      `CHK(c, 16'h1388)
      ana(16'h0960);
      `CHK(c, 16'h09C4)
      ana_mode = AM_OFF;
      ana(16'h0FA0);
      `CHK(c, 16'h0000)
      ana_mode = AM_ABS;
      for (int a = 0; a < 9; a++) begin
         cfg[0].max_action = icc_action_e'(a);
         cfg[0].min_action = icc_action_e'(a);
         ana(16'h09C4);
         ana(16'h11F8);
         if (a > 0) `CHK(e, 1'b1)
         `CHK(hi_act[0], cfg[0].max_action)
         `CHK(lo_act[0], ACT_NONE)
         ana(16'h0190);
         `CHK(lo_act[0], cfg[0].min_action)
      end
      cfg[0].cal_min = 16'h00C8;
      cfg[0].cal_ctr = 16'h00C8;
      cfg[0].cal_max = 16'h1194;
      ana_val(16'h00C8, 12'h000);
      ana_val(16'h0064, 12'h000);
      ana_val(16'h11F8, 12'h3E8);
      cfg[0].cal_min = 16'h03E8;
      cfg[0].cal_ctr = 16'h09C4;
      cfg[0].cal_max = 16'h0FA0;
      cfg[0].deadband_pct = 6'h14;
      ana_val(16'h0A5A, 12'h000);
      ana_val(16'h0FA0, 12'h3E8);
      ana_val(16'h03E8, 12'hC18);
      cfg[0].deadband_pct = 6'h32;
      ana_val(16'h0C1C, 12'h000);
      cfg[0].deadband_pct = 6'h00;
      for (int k = 0; k < 7; k++) begin
         cfg[0].curve = icc_curve_e'(k);
         ana_val(16'h0C1C, crv[k]);
      end
      pul(PM_WIDTH, 16'h0032, 16'h0032, 400, 16'h0002);
      pul(PM_DUTY, 16'h0019, 16'h004B, 500, 16'h00FA);
      `CHK(fb[1], 12'hE0C)
      `CHK(val[1], 12'hE0C)
      pul(PM_FREQ, 16'h01F4, 16'h01F4, 3000, 16'h61A8);
      pul_mode = PM_OFF;
      cyc(20);
      `CHK(cap[1], 16'h0000)
      src_en = 1'b0;
      hi_cyc = 16'h0005;
      lo_cyc = 16'h0005;
      pul_mode = PM_COUNT;
      cyc(4);
      src_en = 1'b1;
      cyc(100);
      src_en = 1'b0;
      cyc(6);
      qry();
      `CHK(cnt, 32'h0000000A)
      `CHK(cap[1], 16'h000A)
      // Enable low freezes the capture even though the mode is off
      ce = 1'b0;
      pul_mode = PM_OFF;
      cyc(4);
      `CHK(cap[1], 16'h000A)
      ce = 1'b1;
      cyc(4);
      pul_mode = PM_COUNT;
      cyc(4);
      qry();
      `CHK(cnt, 32'h00000000)
      test_done();
   end
endmodule : icc_chain_test
`default_nettype wire

// ### tb/icc_pulse_src.sv
// Pulse-output sensor model for the pulse input
`timescale 1ns/1ps
`default_nettype none
module icc_pulse_src (
   input  wire logic        clk_in,
   input  wire logic        en_in,
   input  wire logic [15:0] hi_in,
   input  wire logic [15:0] lo_in,
   output logic             pulse_out
);
   int n = 0;
   initial pulse_out = 1'b0;
   // Idles low when off, so every frame starts with a clean rise
   always @(posedge clk_in) begin
      pulse_out <= #1 en_in && (n < hi_in);
      n         <= en_in ? (n + 1) % (hi_in + lo_in) : 0;
   end
endmodule : icc_pulse_src
`default_nettype wire
